// ===== hdl/envelope_pkg.sv
/*
  Constants, types and helpers shared by the three-voice envelope block.
  Assumes a single 25 MHz system clock and synchronous active-low reset.
*/
package envelope_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ    = 25_000_000;
  localparam int MASTER_CLK_HZ = 1_020_000;
  localparam int CONCERT_A_HZ  = 440;
  localparam int MS_PER_S      = 1000;
  localparam int CYC_PER_MS    = SYS_CLK_HZ / MS_PER_S;
  localparam logic [15:0] TICK_INC = 16'(MASTER_CLK_HZ / MS_PER_S);
  localparam logic [15:0] TICK_MOD = 16'(SYS_CLK_HZ / MS_PER_S);

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int VOICES       = 3;
  localparam int ADDR_W       = 5;
  localparam int DATA_W       = 8;
  localparam int FREQ_W       = 16;
  localparam int PHASE_W      = 24;
  localparam int WAVE_W       = 12;
  localparam int LEVEL_W      = 8;
  localparam int STEP_W       = 24;
  localparam int LEVEL_STEPS  = 255;
  localparam int DECAY_FACTOR = 3;
  localparam logic [7:0] LEVEL_PEAK = 8'hff;
  localparam logic [7:0] LEVEL_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Register map: voice index in addr[4:3], register in addr[2:0]
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_FREQ_LO  = 3'h0;
  localparam logic [2:0] OFS_FREQ_HI  = 3'h1;
  localparam logic [2:0] OFS_CONTROL  = 3'h2;
  localparam logic [2:0] OFS_ATK_DEC  = 3'h3;
  localparam logic [2:0] OFS_SUS_REL  = 3'h4;
  localparam logic [2:0] OFS_LEVEL    = 3'h5;
  localparam logic [2:0] OFS_PHASE    = 3'h6;
  localparam logic [2:0] OFS_WAVE     = 3'h7;
  localparam int         KEY_ON_BIT   = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] FREQ_RST   = 16'h0000;
  localparam logic [3:0]  RATE_RST   = 4'h0;
  localparam logic [3:0]  SUSTAIN_RST = 4'h0;
  localparam logic [7:0]  RDATA_RST  = 8'h00;

  typedef enum logic [1:0] {
    ENV_IDLE    = 2'b00,
    ENV_ATTACK  = 2'b01,
    ENV_DECAY   = 2'b10,
    ENV_RELEASE = 2'b11
  } env_phase_t;

  typedef struct packed {
    logic [15:0] freq;
    logic        key_on;
    logic [3:0]  attack;
    logic [3:0]  decay;
    logic [3:0]  sustain;
    logic [3:0]  release_rate;
  } voice_cfg_t;

  // Nominal full-scale attack time in ms per rate code
  function automatic int attack_ms(input logic [3:0] code);
    unique case (code)
      4'h0: attack_ms = 2;
      4'h1: attack_ms = 8;
      4'h2: attack_ms = 16;
      4'h3: attack_ms = 24;
      4'h4: attack_ms = 38;
      4'h5: attack_ms = 56;
      4'h6: attack_ms = 68;
      4'h7: attack_ms = 80;
      4'h8: attack_ms = 100;
      4'h9: attack_ms = 250;
      4'ha: attack_ms = 500;
      4'hb: attack_ms = 800;
      4'hc: attack_ms = 1000;
      4'hd: attack_ms = 3000;
      4'he: attack_ms = 5000;
      4'hf: attack_ms = 8000;
    endcase
  endfunction : attack_ms

endpackage : envelope_pkg

// ===== hdl/tone_oscillator.sv
/*
  Phase-accumulating tone oscillator for one voice.
  Assumes a one-cycle master tick at the nominal master clock rate.
*/
`timescale 1ns/1ps
module tone_oscillator (
  input  wire logic                             sys_clk,
  input  wire logic                             rst_n,
  input  wire logic                             tick,
  input  wire logic [envelope_pkg::FREQ_W-1:0]  freq_word,
  output logic      [envelope_pkg::WAVE_W-1:0]  wave
);
  import envelope_pkg::*;

  logic [PHASE_W-1:0] phase;

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  // proportional pitch
  // Output rate is freq_word * master / 2^24, so a halved word is an
  // octave lower exactly; wrap-around is the intended modulo.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (tick) begin
      phase <= phase + PHASE_W'(freq_word);
    end
  end

  // Sawtooth taken from the top bits of the flop
  assign wave = phase[PHASE_W-1 -: WAVE_W];

endmodule : tone_oscillator

// ===== hdl/envelope_voices.sv
/*
  Three-voice tone and ADSR envelope block with a plain register port.
  Assumes a host issuing one-cycle read or write strobes on sys_clk;
  read data appear in the cycle after the read strobe.
*/
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
module envelope_voices #(
  parameter int CYC_PER_MS_P = envelope_pkg::CYC_PER_MS
) (
  input  wire logic                                       sys_clk,
  input  wire logic                                       rst_n,
  input  wire logic [envelope_pkg::ADDR_W-1:0]            addr,
  input  wire logic [envelope_pkg::DATA_W-1:0]            wdata,
  input  wire logic                                       wr,
  input  wire logic                                       rd,
  output logic      [envelope_pkg::DATA_W-1:0]            rdata,
  output logic [envelope_pkg::VOICES-1:0][envelope_pkg::LEVEL_W-1:0]
                                                          env_level,
  output logic [envelope_pkg::VOICES-1:0][envelope_pkg::WAVE_W-1:0]
                                                          wave_out
);
  import envelope_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  voice_cfg_t             cfg      [VOICES];
  env_phase_t             phase    [VOICES];
  logic [LEVEL_W-1:0]     level    [VOICES];
  logic [STEP_W-1:0]      step_cnt [VOICES];
  logic [STEP_W-1:0]      period   [VOICES];
  logic                   key_prev [VOICES];
  logic [15:0]            tick_acc;
  logic                   tick;
  logic [1:0]             sel_voice;
  logic [2:0]             sel_reg;
  logic [DATA_W-1:0]      next_rdata;

  assign sel_voice = addr[4:3];
  assign sel_reg   = addr[2:0];

  // Step period in system cycles for one level step of a segment
  function automatic logic [STEP_W-1:0] step_period(
    input logic [3:0] code,
    input int         factor
  );
    int total;
    total = attack_ms(code) * factor * CYC_PER_MS_P / LEVEL_STEPS;
    if (total < 1) begin
      total = 1;
    end
    step_period = STEP_W'(total);
  endfunction : step_period

  // ----------------------------------------------------------------
  // Master clock tick
  // ----------------------------------------------------------------
  // master clock rate
  // Fractional divider gives the 1.02 MHz average rate the frequency
  // word table expects; jitter of one system cycle is inaudible.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_acc <= '0;
      tick     <= 1'b0;
    end else if (tick_acc + TICK_INC >= TICK_MOD) begin
      tick_acc <= tick_acc + TICK_INC - TICK_MOD;
      tick     <= 1'b1;
    end else begin
      tick_acc <= tick_acc + TICK_INC;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Per-voice logic
  // ----------------------------------------------------------------
  for (genvar v = 0; v < VOICES; v++) begin : g_voice

    // Register writes
    // rate and sustain codes
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        cfg[v].freq         <= FREQ_RST;
        cfg[v].key_on       <= 1'b0;
        cfg[v].attack       <= RATE_RST;
        cfg[v].decay        <= RATE_RST;
        cfg[v].sustain      <= SUSTAIN_RST;
        cfg[v].release_rate <= RATE_RST;
      end else if (wr && sel_voice == 2'(v)) begin
        unique case (sel_reg)
          OFS_FREQ_LO: begin
            cfg[v].freq[7:0] <= wdata;
          end
          OFS_FREQ_HI: begin
            cfg[v].freq[15:8] <= wdata;
          end
          OFS_CONTROL: begin
            cfg[v].key_on <= wdata[KEY_ON_BIT];
          end
          OFS_ATK_DEC: begin
            cfg[v].attack <= wdata[7:4];
            cfg[v].decay  <= wdata[3:0];
          end
          OFS_SUS_REL: begin
            cfg[v].sustain      <= wdata[7:4];
            cfg[v].release_rate <= wdata[3:0];
          end
          OFS_LEVEL, OFS_PHASE, OFS_WAVE: begin
            cfg[v].key_on <= cfg[v].key_on;
          end
        endcase
      end
    end

    // Segment step period from the active phase
    // segment times
    // Decay and release run three times slower than attack per code.
    always_comb begin
      unique case (phase[v])
        ENV_ATTACK:  period[v] = step_period(cfg[v].attack, 1);
        ENV_DECAY:   period[v] = step_period(cfg[v].decay, DECAY_FACTOR);
        ENV_RELEASE: period[v] = step_period(cfg[v].release_rate,
                                             DECAY_FACTOR);
        ENV_IDLE:    period[v] = STEP_W'(1);
      endcase
    end

    // Key-on edge memory
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        key_prev[v] <= 1'b0;
      end else begin
        key_prev[v] <= cfg[v].key_on;
      end
    end

    // Envelope state machine and level
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        phase[v]    <= ENV_IDLE;
        level[v]    <= LEVEL_ZERO;
        step_cnt[v] <= '0;
      end else if (cfg[v].key_on && !key_prev[v]) begin
        // Retrigger starts from the current level to avoid a click
        phase[v]    <= ENV_ATTACK;
        step_cnt[v] <= '0;
      end else if (!cfg[v].key_on &&
                   (phase[v] == ENV_ATTACK || phase[v] == ENV_DECAY)) begin
        phase[v]    <= ENV_RELEASE;
        step_cnt[v] <= '0;
      end else if (step_cnt[v] >= period[v] - STEP_W'(1)) begin
        step_cnt[v] <= '0;
        unique case (phase[v])
          ENV_IDLE: begin
            level[v] <= LEVEL_ZERO;
          end
          ENV_ATTACK: begin
            if (level[v] >= LEVEL_PEAK - 8'h01) begin
              level[v] <= LEVEL_PEAK;
              phase[v] <= ENV_DECAY;
            end else begin
              level[v] <= level[v] + 8'h01;
            end
          end
          ENV_DECAY: begin
            // zero sustain
            // Target is sustain * 17, so code f is the full peak.
            if (level[v] > {cfg[v].sustain, cfg[v].sustain}) begin
              level[v] <= level[v] - 8'h01;
            end
          end
          ENV_RELEASE: begin
            if (level[v] == LEVEL_ZERO) begin
              phase[v] <= ENV_IDLE;
            end else begin
              level[v] <= level[v] - 8'h01;
            end
          end
        endcase
      end else begin
        step_cnt[v] <= step_cnt[v] + STEP_W'(1);
      end
    end

    // Level output register
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        env_level[v] <= LEVEL_ZERO;
      end else begin
        env_level[v] <= level[v];
      end
    end

    // Tone generator
    // proportional pitch
    tone_oscillator u_osc (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .tick      (tick),
      .freq_word (cfg[v].freq),
      .wave      (wave_out[v])
    );

  end : g_voice

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unmapped voice slot and idle cycles read as zero
  always_comb begin
    next_rdata = RDATA_RST;
    for (int v = 0; v < VOICES; v++) begin
      if (rd && sel_voice == 2'(v)) begin
        unique case (sel_reg)
          OFS_FREQ_LO: next_rdata = cfg[v].freq[7:0];
          OFS_FREQ_HI: next_rdata = cfg[v].freq[15:8];
          OFS_CONTROL: next_rdata = {7'h00, cfg[v].key_on};
          OFS_ATK_DEC: next_rdata = {cfg[v].attack, cfg[v].decay};
          OFS_SUS_REL: next_rdata = {cfg[v].sustain,
                                     cfg[v].release_rate};
          OFS_LEVEL:   next_rdata = level[v];
          OFS_PHASE:   next_rdata = {6'h00, phase[v]};
          OFS_WAVE:    next_rdata = wave_out[v][WAVE_W-1 -: DATA_W];
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata <= RDATA_RST;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule : envelope_voices

// ===== bench/envelope_voices_properties.sv
/*
  Port checker for the three-voice envelope block.
  Assumes a bind into envelope_voices with one clock, synchronous reset.
*/
`timescale 1ns/1ps
module envelope_checker (
  input wire logic                               sys_clk,
  input wire logic                               rst_n,
  input wire logic [envelope_pkg::ADDR_W-1:0]    addr,
  input wire logic [envelope_pkg::DATA_W-1:0]    wdata,
  input wire logic                               wr,
  input wire logic                               rd,
  input wire logic [envelope_pkg::DATA_W-1:0]    rdata,
  input wire logic [envelope_pkg::VOICES-1:0][envelope_pkg::LEVEL_W-1:0]
                                                 env_level,
  input wire logic [envelope_pkg::VOICES-1:0][envelope_pkg::WAVE_W-1:0]
                                                 wave_out
);
  import envelope_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence rd_of(int v, logic [2:0] ofs);
    rd && addr == 5'(v * 8 + ofs);
  endsequence

  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not idle");
  unmapped_read_a: assert property (rd && addr[4:3] == 2'h3 |=> !rdata)
    else $error("unmapped read not zero");
  reset_state_a: assert property (disable iff (1'b0)
    !rst_n |=> rdata == 8'h00 && env_level == '0 && wave_out == '0)
    else $error("outputs not cleared by reset");

  for (genvar v = 0; v < VOICES; v++) begin : g_v
    phase_code_a: assert property (rd_of(v, OFS_PHASE) |=> !rdata[7:2])
      else $error("phase code out of range");
    level_read_a: assert property (
      rd_of(v, OFS_LEVEL) |=> rdata == env_level[v])
      else $error("level read differs from output");
    // Levels move one count at a time
    level_step_a: assert property ($changed(env_level[v]) |->
      8'(env_level[v] - $past(env_level[v])) inside {8'h01, 8'hff})
      else $error("level jumped");
    // Shortest step period is two cycles
    step_gap_a: assert property ($changed(env_level[v]) |=>
      $stable(env_level[v])) else $error("level steps too close");
    wave_step_a: assert property (
      12'(wave_out[v] - $past(wave_out[v])) <= 12'h010)
      else $error("wave step too large");
  end
endmodule : envelope_checker

bind envelope_voices envelope_checker i_chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .env_level(env_level), .wave_out(wave_out));

// ===== bench/host_bus_model.sv
/*
  Host processor model driving the plain register port.
  Assumes read data stand only in the cycle after the read strobe.
*/
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic                            sys_clk,
  output logic [envelope_pkg::ADDR_W-1:0]      addr,
  output logic [envelope_pkg::DATA_W-1:0]      wdata,
  output logic                                 wr,
  output logic                                 rd,
  input  wire logic [envelope_pkg::DATA_W-1:0] rdata
);
  import envelope_pkg::*;
  initial begin
    addr = 5'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Released lines show the inverse, never a stale value
  task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : write_reg
  task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge sys_clk);
    d = rdata;
  endtask : read_reg
endmodule : host_bus_model

// ===== bench/test_envelope_voices.sv
/*
  Self-checking bench for the envelope block.
  Assumes the step scale is shortened to 255 cycles per ms.
*/
`timescale 1ns/1ps
`define CHECK_EQ(g, e) begin tests_run++; if ((g) !== (e)) begin \
  num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_envelope_voices;
  import envelope_pkg::*;
  logic                             sys_clk;
  logic                             rst_n;
  logic [ADDR_W-1:0]                addr;
  logic [DATA_W-1:0]                wdata;
  logic                             wr;
  logic                             rd;
  logic [DATA_W-1:0]                rdata;
  logic [VOICES-1:0][LEVEL_W-1:0]   env_level;
  logic [VOICES-1:0][WAVE_W-1:0]    wave_out;
  logic [7:0]                       d;
  int                               n;
  int                               p;
  int                               num_errors;
  int                               tests_run;
  longint                           e;

  host_bus_model hb (.sys_clk(sys_clk), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  envelope_voices #(.CYC_PER_MS_P(255)) i_dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .env_level(env_level), .wave_out(wave_out));

  always #20 sys_clk = ~sys_clk;

  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  function automatic logic [4:0] ra(input int v, input logic [2:0] o);
    ra = {2'(v), o};
  endfunction : ra
  task automatic wait_level(input int v, input logic [7:0] lv, output int c);
    c = 0;
    while (env_level[v] !== lv) begin
      @(posedge sys_clk);
      c++;
      if (c > 14000) begin
        `CHECK_EQ(env_level[v], lv)
        end_of_test();
      end
    end
  endtask : wait_level
  task automatic wait_msb(input logic b, output int c);
    c = 0;
    while (wave_out[0][11] !== b) begin
      @(posedge sys_clk);
      c++;
      if (c > 30000) begin
        `CHECK_EQ(wave_out[0][11], b)
        end_of_test();
      end
    end
  endtask : wait_msb
  // Cycles between two wraps of the voice 0 sawtooth
  task automatic period(output int c);
    int a;
    wait_msb(1'b1, a);
    wait_msb(1'b0, a);
    wait_msb(1'b1, a);
    wait_msb(1'b0, c);
    c += a;
  endtask : period
  task automatic key(input int v, input logic [7:0] ad, input logic [7:0] sr);
    hb.write_reg(ra(v, OFS_ATK_DEC), ad);
    hb.write_reg(ra(v, OFS_SUS_REL), sr);
    hb.write_reg(ra(v, OFS_CONTROL), 8'h01);
  endtask : key
  task automatic phase_is(input int v, input logic [7:0] ph);
    hb.read_reg(ra(v, OFS_PHASE), d);
    `CHECK_EQ(d, ph)
  endtask : phase_is

  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    num_errors = 0;
    tests_run = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    hb.read_reg(ra(0, OFS_ATK_DEC), d);
    `CHECK_EQ(d, 8'h00)
    hb.write_reg(ra(0, OFS_ATK_DEC), 8'ha8);
    hb.read_reg(ra(0, OFS_ATK_DEC), d);
    `CHECK_EQ(d, 8'ha8)
    hb.write_reg(ra(3, OFS_CONTROL), 8'h01);
    hb.read_reg(ra(3, OFS_CONTROL), d);
    `CHECK_EQ(d, 8'h00)
    phase_is(0, 8'h00);
    $display("test registers done");
    key(0, 8'h09, 8'he0);
    wait_level(0, 8'hff, n);
    `CHECK_EQ(n inside {[505:520]}, 1'b1)
    wait_level(0, 8'hee, n);
    `CHECK_EQ(n inside {[12740:12760]}, 1'b1)
    repeat (2000) @(posedge sys_clk);
    `CHECK_EQ(env_level[0], 8'hee)
    phase_is(0, 8'h02);
    hb.write_reg(ra(0, OFS_CONTROL), 8'h00);
    phase_is(0, 8'h03);
    wait_level(0, 8'h00, n);
    `CHECK_EQ(n inside {[1410:1440]}, 1'b1)
    $display("test sustain done");
    key(1, 8'h09, 8'h00);
    wait_level(1, 8'hff, n);
    repeat (100) @(posedge sys_clk);
    hb.write_reg(ra(1, OFS_CONTROL), 8'h00);
    phase_is(1, 8'h03);
    wait_level(1, 8'h00, n);
    `CHECK_EQ(n inside {[1500:1540]}, 1'b1)
    key(2, 8'h00, 8'h00);
    wait_level(2, 8'hff, n);
    wait_level(2, 8'h00, n);
    `CHECK_EQ(n inside {[1520:1540]}, 1'b1)
    phase_is(2, 8'h02);
    $display("test percussion done");
    hb.write_reg(ra(0, OFS_FREQ_LO), 8'hfe);
    hb.write_reg(ra(0, OFS_FREQ_HI), 8'hff);
    period(p);
    e = (64'd1 << 24) * 25000 / (64'd65534 * 1020);
    `CHECK_EQ(p inside {[e - 40:e + 40]}, 1'b1)
    hb.write_reg(ra(0, OFS_FREQ_LO), 8'hff);
    hb.write_reg(ra(0, OFS_FREQ_HI), 8'h7f);
    period(n);
    `CHECK_EQ(n inside {[2 * p - 60:2 * p + 60]}, 1'b1)
    $display("test pitch done");
    end_of_test();
  end
endmodule : test_envelope_voices
